// ### design/ispc_params.svh
`ifndef ISPC_PARAMS_SVH
`define ISPC_PARAMS_SVH

// Width of the word address carried on the port, bits 31:2.
`define ISPC_ADDR_W 30
// Number of byte lanes on the port.
`define ISPC_BE_W 4
// Lowest and highest port address bit that carries the sync type.
`define ISPC_SYNC_LSB 6
`define ISPC_SYNC_MSB 10
// Width of the sync type field.
`define ISPC_STYPE_W 5
// Default depth of the request FIFO.
`define ISPC_FIFO_DEPTH 8
// Cycles that the pin synchroniser needs before a stall level can be trusted.
`define ISPC_SYNC_LAT 3
// Reset value of every single-bit memory-side port output.
`define ISPC_RST_VAL 1'h0

`endif

// ### design/ispc_pkg.sv
package ispc_pkg;

  // Kind of transaction that the core asks the port to run.
  typedef enum logic [1:0] {
    ISPC_FETCH,
    ISPC_READ,
    ISPC_WRITE,
    ISPC_SYNC
  } ispc_kind_t;

  // One request from the core, queued in the FIFO.
  typedef struct packed {
    logic [29:0] word_addr;
    logic [3:0]  byte_en;
    ispc_kind_t  kind;
    logic [4:0]  sync_type;
    logic        load_linked;
    logic        store_conditional;
    logic        bp_hit;
    logic        call;
    logic        link_offset;
  } ispc_req_t;

  // Completion report back to the core.
  typedef struct packed {
    logic valid;
    logic bus_error;
    logic aborted;
    logic unlocked;
  } ispc_done_t;

endpackage

// ### design/ispc_fifo.sv
`timescale 1ns/1ps
// Flop-based FIFO with valid and ready on both sides.
module ispc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse depths that the pointer logic cannot wrap correctly.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : g_bad
    $error("ispc_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words.
  logic [AW-1:0]    wr_ptr;       // Next slot to write.
  logic [AW-1:0]    rd_ptr;       // Oldest slot.
  logic [AW:0]      count;        // Words held.
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  // Full and empty come straight from the count.
  assign in_ready_o  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Pointer and count bookkeeping.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data storage is written only on an accepted push.
  always_ff @(posedge clk_i)
  begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule // ispc_fifo

// ### design/ispc_sync.sv
`timescale 1ns/1ps
// Three-flop pin synchroniser; a change is taken once stages two and three agree.
module ispc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0]      level_o
);
  if (WIDTH < 1)
  begin : g_bad
    $error("ispc_sync needs at least one bit");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic s1;  // First stage, read only by the second.
    logic s2;  // Second stage.
    logic s3;  // Third stage.
    // The filtered level follows only when two stages agree.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        s1         <= 1'b0;
        s2         <= 1'b0;
        s3         <= 1'b0;
        level_o[i] <= 1'b0;
      end
      else
      begin
        s1 <= pin_i[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) level_o[i] <= s3;
      end
    end
  end
endmodule // ispc_sync

// ### design/ispc_port.sv
`timescale 1ns/1ps
`include "ispc_params.svh"

module ispc_port #(
  parameter int FIFO_DEPTH = `ISPC_FIFO_DEPTH,
  parameter int SYNC_LAT   = `ISPC_SYNC_LAT
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Core request side.
  input  wire logic               req_valid_i,
  input  wire ispc_pkg::ispc_req_t req_i,
  output logic                    req_ready_o,
  input  wire logic               abort_i,
  input  wire logic               exception_return_i,
  input  wire logic               inst_bp_armed_i,
  input  wire logic               data_bp_armed_i,
  input  wire logic               unified_mode_i,
  output ispc_pkg::ispc_done_t    done_o,
  // Memory port side.
  output logic [31:2]             port_address_o,
  output logic [3:0]              port_byte_enables_o,
  output logic                    port_read_strobe_o,
  output logic                    port_write_strobe_o,
  output logic                    sync_strobe_o,
  output logic                    fetch_type_qualifier_o,
  output logic                    write_buffer_control_o,
  output logic                    abort_request_o,
  output logic                    breakpoint_enabled_o,
  output logic                    break_detected_o,
  output logic                    lock_marker_o,
  output logic                    unlock_marker_o,
  output logic                    unlock_all_pulse_o,
  output logic                    call_fetch_hint_o,
  output logic                    link_offset_o,
  input  wire logic               port_stall_i,
  input  wire logic               port_error_i,
  input  wire logic               abort_acknowledge_i,
  input  wire logic               unlock_ack_i
);
  localparam int RW = $bits(ispc_pkg::ispc_req_t);
  localparam int CW = (SYNC_LAT > 1) ? $clog2(SYNC_LAT + 1) : 1;

  // The wait counter must cover the synchroniser delay.
  if (SYNC_LAT < 1 || FIFO_DEPTH < 2)
  begin : g_bad
    $error("ispc_port needs SYNC_LAT >= 1 and FIFO_DEPTH >= 2");
  end

  // Port sequencer states.
  typedef enum logic [1:0] {
    ISPC_IDLE,
    ISPC_START,
    ISPC_WAIT
  } ispc_state_t;

  ispc_state_t         state;       // Current sequencer state.
  ispc_state_t         next_state;  // State for the next cycle.
  logic [CW-1:0]       wait_cnt;    // Cycles left before stall is trusted.
  ispc_pkg::ispc_req_t cur;         // Transaction on the port.
  ispc_pkg::ispc_req_t head;        // Oldest queued request.
  logic [RW-1:0]       head_bits;   // Raw FIFO output.
  logic                head_valid;  // A request is queued.
  logic [3:0]          pin_lvl;     // Synchronised port inputs.
  logic                exception_return_q;      // Previous exception-return level.

  // Decodes a request kind into the read strobe condition.
  function automatic logic port_read_strobe_kind(input ispc_pkg::ispc_kind_t k);
    return (k == ispc_pkg::ISPC_FETCH) || (k == ispc_pkg::ISPC_READ);
  endfunction

  // Pin inputs come from the memory glue and are synchronised here.
  ispc_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({unlock_ack_i, abort_acknowledge_i, port_error_i, port_stall_i}),
    .level_o (pin_lvl)
  );

  wire stall_s   = pin_lvl[0];  // Memory not yet ready.
  wire error_s   = pin_lvl[1];  // Transaction failed.
  wire ack_s     = pin_lvl[2];  // Transaction was aborted.
  wire unlock_s  = pin_lvl[3];  // Store-conditional lock held.

  // Terminating cycle: the wait is over and the stall has been released.
  // Stall release ends transaction.
  wire term      = (state == ISPC_WAIT) && (wait_cnt == '0) && !stall_s;
  wire pop       = (state == ISPC_IDLE) && head_valid;

  // Requests queue here so a slow memory back-pressures the core.
  ispc_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (req_valid_i),
    .in_data_i   (req_i),
    .in_ready_o  (req_ready_o),
    .out_valid_o (head_valid),
    .out_data_o  (head_bits),
    .out_ready_i (pop)
  );

  assign head = ispc_pkg::ispc_req_t'(head_bits);

  // Pending assumed to end now.
  // A read could start next cycle if the port is idle, or would be idle
  // once the pending transaction ends, and a read heads the queue.
  wire port_free = (state == ISPC_IDLE) || (state == ISPC_WAIT);
  wire next_wbc  = !(port_free && head_valid && port_read_strobe_kind(head.kind));

  // Sequencer next state.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ISPC_IDLE:
      begin
        // Start a transaction as soon as one is queued.
        if (head_valid) next_state = ISPC_START;
      end
      ISPC_START:
      begin
        // Strobes stand for the start cycle only.
        next_state = ISPC_WAIT;
      end
      ISPC_WAIT:
      begin
        // Return to idle once memory releases the stall.
        if (term) next_state = ISPC_IDLE;
      end
    endcase
  end

  // Sequencer state and wait counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state    <= ISPC_IDLE;
      wait_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == ISPC_START) wait_cnt <= CW'(SYNC_LAT);
      else if (wait_cnt != '0) wait_cnt <= wait_cnt - CW'(1);
    end
  end

  // The transaction is captured once and held until it ends.
  // Held stable while stalled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) cur <= '0;
    else if (pop) cur <= head;
  end

  // Address and enables come straight from the held transaction.
  // Sync type on 10:6.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_address_o      <= '0;
      port_byte_enables_o <= '0;
    end
    else if (pop)
    begin
      port_address_o <= head.word_addr;
      if (head.kind == ispc_pkg::ISPC_SYNC)
        port_address_o[`ISPC_SYNC_MSB:`ISPC_SYNC_LSB] <= head.sync_type;
      port_byte_enables_o <= head.byte_en;
    end
  end

  // Strobes are one-cycle pulses in the start cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_read_strobe_o  <= `ISPC_RST_VAL;
      port_write_strobe_o <= `ISPC_RST_VAL;
      sync_strobe_o       <= `ISPC_RST_VAL;
    end
    else
    begin
      port_read_strobe_o  <= pop && port_read_strobe_kind(head.kind);
      port_write_strobe_o <= pop && (head.kind == ispc_pkg::ISPC_WRITE);
      sync_strobe_o       <= pop && (head.kind == ispc_pkg::ISPC_SYNC);
    end
  end

  // Qualifiers and markers stand for the whole transaction.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fetch_type_qualifier_o <= `ISPC_RST_VAL;
      lock_marker_o          <= `ISPC_RST_VAL;
      unlock_marker_o        <= `ISPC_RST_VAL;
    end
    else if (pop)
    begin
      fetch_type_qualifier_o <= (head.kind == ispc_pkg::ISPC_FETCH);
      lock_marker_o <= head.load_linked && (head.kind == ispc_pkg::ISPC_READ);
      unlock_marker_o <= head.store_conditional && (head.kind == ispc_pkg::ISPC_WRITE);
    end
    else if (term)
    begin
      lock_marker_o   <= 1'b0;
      unlock_marker_o <= 1'b0;
    end
  end

  // Call hint and link offset stand in the start cycle of the fetch.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      call_fetch_hint_o <= `ISPC_RST_VAL;
      link_offset_o     <= `ISPC_RST_VAL;
    end
    else
    begin
      call_fetch_hint_o <= pop && head.call && (head.kind == ispc_pkg::ISPC_FETCH);
      link_offset_o     <= pop && head.call && head.link_offset &&
                           (head.kind == ispc_pkg::ISPC_FETCH);
    end
  end

  // Abort request latches while busy and drops after the final cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) abort_request_o <= `ISPC_RST_VAL;
    else if (term) abort_request_o <= 1'b0;
    else if (state != ISPC_IDLE && abort_i) abort_request_o <= 1'b1;
  end

  // Break indication rises one cycle after the start cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) break_detected_o <= `ISPC_RST_VAL;
    else if (term) break_detected_o <= 1'b0;
    else if (state == ISPC_START && cur.bp_hit) break_detected_o <= 1'b1;
  end

  // Breakpoint-enabled and write-buffer control are registered levels.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      breakpoint_enabled_o   <= `ISPC_RST_VAL;
      write_buffer_control_o <= `ISPC_RST_VAL;
    end
    else
    begin
      breakpoint_enabled_o   <= inst_bp_armed_i || (unified_mode_i && data_bp_armed_i);
      write_buffer_control_o <= next_wbc;
    end
  end

  // Exception return gives exactly one pulse per rising edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      exception_return_q             <= 1'b0;
      unlock_all_pulse_o <= `ISPC_RST_VAL;
    end
    else
    begin
      exception_return_q             <= exception_return_i;
      unlock_all_pulse_o <= exception_return_i && !exception_return_q;
    end
  end

  // Completion report to the core, one cycle after the final cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) done_o <= '0;
    else
    begin
      done_o.valid     <= term;
      done_o.bus_error <= term && (error_s || (ack_s && !abort_request_o));
      done_o.aborted   <= term && ack_s && abort_request_o;
      done_o.unlocked  <= term && unlock_s && unlock_marker_o;
    end
  end
endmodule // ispc_port

// ### tb/ispc_port_sva.sv
`timescale 1ns/1ps
// Watches the memory-side outputs of the instruction-side port.
module ispc_port_chk (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 exception_return_i,
  input wire logic                 inst_bp_armed_i,
  input wire logic                 data_bp_armed_i,
  input wire logic                 unified_mode_i,
  input wire ispc_pkg::ispc_done_t done_o,
  input wire logic [31:2]          port_address_o,
  input wire logic [3:0]           port_byte_enables_o,
  input wire logic                 port_read_strobe_o,
  input wire logic                 port_write_strobe_o,
  input wire logic                 sync_strobe_o,
  input wire logic                 fetch_type_qualifier_o,
  input wire logic                 write_buffer_control_o,
  input wire logic                 abort_request_o,
  input wire logic                 breakpoint_enabled_o,
  input wire logic                 break_detected_o,
  input wire logic                 lock_marker_o,
  input wire logic                 unlock_marker_o,
  input wire logic                 unlock_all_pulse_o,
  input wire logic                 call_fetch_hint_o,
  input wire logic                 link_offset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Any of the three strobes marks the first cycle of a transaction.
  wire start = port_read_strobe_o | port_write_strobe_o | sync_strobe_o;
  wr_not_fetch_a: assert property (
    port_write_strobe_o |-> !fetch_type_qualifier_o) else $error("write strobe on a fetch");
  rd_wbc_low_a: assert property (
    port_read_strobe_o |-> !write_buffer_control_o) else $error("buffer control high at a read");
  abort_hold_a: assert property (
    $fell(abort_request_o) |-> done_o.valid) else $error("abort request dropped early");
  break_late_a: assert property (
    $rose(break_detected_o) |-> $past(start)) else $error("break not one cycle after start");
  addr_stable_a: assert property (
    !start |-> $stable({port_address_o, port_byte_enables_o, fetch_type_qualifier_o}))
    else $error("address moved within a transaction");
  lock_read_a: assert property (
    lock_marker_o |-> !fetch_type_qualifier_o && !port_write_strobe_o) else $error("bad lock");
  unlock_write_a: assert property (
    unlock_marker_o |-> !fetch_type_qualifier_o && !port_read_strobe_o) else $error("bad unlock");
  bp_enable_a: assert property (
    breakpoint_enabled_o == $past(inst_bp_armed_i | (unified_mode_i & data_bp_armed_i)))
    else $error("breakpoint enable wrong");
  ual_once_a: assert property (
    unlock_all_pulse_o |=> !unlock_all_pulse_o) else $error("unlock-all longer than a cycle");
  ual_cause_a: assert property (
    $rose(exception_return_i) |-> ##[1:3] unlock_all_pulse_o) else $error("unlock-all missing");
  link_with_call_a: assert property (
    link_offset_o |-> call_fetch_hint_o) else $error("link offset without call hint");
  call_on_fetch_a: assert property (
    call_fetch_hint_o |-> port_read_strobe_o && fetch_type_qualifier_o) else $error("bad call");
  // The main traffic kinds that the bench should reach.
  cover property (port_write_strobe_o && unlock_marker_o);
  cover property ($fell(abort_request_o));
  cover property (break_detected_o && lock_marker_o);
endmodule // ispc_port_chk

bind ispc_port ispc_port_chk u_chk (.*);

// ### tb/ispc_mem_model.sv
`timescale 1ns/1ps
// Memory and glue model: stalls each transaction, then reports its outcome.
module ispc_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       abort_request_i,
  input  wire logic [7:0] wait_i,
  input  wire logic       err_i,
  input  wire logic       stray_ack_i,
  input  wire logic       lock_held_i,
  output logic            stall_o,
  output logic            error_o,
  output logic            ack_o,
  output logic            unlock_ack_o
);
  logic [7:0] cnt; // Stall cycles still to run.
  // Stall every transaction.
  // Stall rises within the start cycle so the synchroniser catches it.
  assign stall_o = start_i | (cnt != 8'h00);
  // Outcome lines load at start and stay until the next start; an abort request during the stall also raises ack_o.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 8'h00;
      error_o <= 1'b0;
      ack_o <= 1'b0;
      unlock_ack_o <= 1'b0;
    end
    else if (start_i)
    begin
      cnt <= wait_i;
      error_o <= err_i;
      ack_o <= stray_ack_i;
      unlock_ack_o <= lock_held_i;
    end
    else if (cnt != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      if (abort_request_i)
        ack_o <= 1'b1;
    end
  end
endmodule // ispc_mem_model

// ### tb/instr_side_sram_port_control_test.sv
`timescale 1ns/1ps
// Self-checking bench for the instruction-side port.
module instr_side_sram_port_control_test;
  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 req_valid_i = 1'b0;
  ispc_pkg::ispc_req_t  req_i = '0;
  logic                 abort_i = 1'b0;
  logic                 exception_return = 1'b0;
  logic                 ibp = 1'b0;
  logic                 dbp = 1'b0;
  logic                 uni = 1'b0;
  logic [7:0]           wait_c = 8'h04; // Stall length the model applies.
  logic                 err_c = 1'b0;
  logic                 ack_c = 1'b0;
  logic                 lock_c = 1'b0;
  wire                  rdy, rd, wr, sy, q, wbc, abr, bpe, brk, lk, ul, ual, cl, lo;
  wire                  stall, perr, pack, uack;
  wire [31:2]           addr;
  wire [3:0]            be;
  ispc_pkg::ispc_done_t done;
  ispc_pkg::ispc_done_t d;      // Completion seen for the last transfer.
  logic [5:0]           s;      // Strobes, qualifier, call and offset at start.
  logic [3:0]           acc;    // Lock, unlock, break and abort seen.
  logic [31:2]          s_addr;
  logic [3:0]           s_be;
  int                   n_errors = 0;
  int                   check_count = 0;

  ispc_port DUT (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .req_ready_o(rdy), .abort_i(abort_i), .exception_return_i(exception_return), .inst_bp_armed_i(ibp),
    .data_bp_armed_i(dbp), .unified_mode_i(uni), .done_o(done), .port_address_o(addr),
    .port_byte_enables_o(be), .port_read_strobe_o(rd), .port_write_strobe_o(wr),
    .sync_strobe_o(sy), .fetch_type_qualifier_o(q), .write_buffer_control_o(wbc),
    .abort_request_o(abr), .breakpoint_enabled_o(bpe), .break_detected_o(brk),
    .lock_marker_o(lk), .unlock_marker_o(ul), .unlock_all_pulse_o(ual),
    .call_fetch_hint_o(cl), .link_offset_o(lo), .port_stall_i(stall), .port_error_i(perr),
    .abort_acknowledge_i(pack), .unlock_ack_i(uack));
  ispc_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .start_i(rd | wr | sy),
    .abort_request_i(abr), .wait_i(wait_c), .err_i(err_c), .stray_ack_i(ack_c),
    .lock_held_i(lock_c), .stall_o(stall), .error_o(perr), .ack_o(pack), .unlock_ack_o(uack));

  // Free-running 50 MHz clock.
  initial forever #10 clk_i = ~clk_i;

  // Prints the verdict once and ends the run.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // Builds a request; f holds load-linked, store-conditional, hit, call, offset.
  function automatic ispc_pkg::ispc_req_t mk(ispc_pkg::ispc_kind_t k, logic [29:0] a,
    logic [3:0] b, logic [4:0] st, logic [4:0] f);
    mk = '{a, b, k, st, f[4], f[3], f[2], f[1], f[0]};
  endfunction

  // Runs one transfer, capturing the start cycle and the completion.
  task automatic xfer(input ispc_pkg::ispc_req_t r, input logic ab);
    int i;
    @(negedge clk_i);
    req_valid_i = 1'b1;
    req_i = r;
    @(negedge clk_i);
    req_valid_i = 1'b0;
    acc = 4'h0;
    for (i = 0; i < 60 && done.valid !== 1'b1; i++)
    begin
      if (rd | wr | sy)
      begin
        s = {rd, wr, sy, q, cl, lo};
        s_addr = addr;
        s_be = be;
        abort_i = ab;
      end
      acc = acc | {lk, ul, brk, abr};
      @(negedge clk_i);
    end
    abort_i = 1'b0;
    d = done;
    if (i == 60)
    begin
      $display("mismatch xfer_done expected 1 seen 0");
      n_errors++;
      tally_and_finish();
    end
  endtask

  // Outputs stay low while reset is held.
  task automatic t_reset();
    repeat (3) @(negedge clk_i);
    chk("reset_out", 32'h0, 32'({rd, wr, sy, abr, ual, brk, lk, ul}));
    rst_i = 1'b0;
  endtask

  // Fetches with both link offsets; idle port then allows buffer flushes.
  task automatic t_fetch();
    for (int k = 0; k < 2; k++)
    begin
      xfer(mk(ispc_pkg::ISPC_FETCH, 30'h2AAAAAA5, 4'hF, 5'h00, 5'(2 + k)), 1'b0);
      chk("fetch_flags", 32'({5'b10011, k[0]}), 32'(s));
      chk("fetch_addr", 32'h2AAAAAA5, 32'(s_addr));
      chk("fetch_done", 32'h8, 32'(d));
    end
    @(negedge clk_i);
    chk("wbc_idle", 32'h1, 32'(wbc));
  endtask

  // Store-conditional write with a held lock.
  task automatic t_write();
    lock_c = 1'b1;
    xfer(mk(ispc_pkg::ISPC_WRITE, 30'h01234567, 4'h3, 5'h00, 5'h08), 1'b0);
    lock_c = 1'b0;
    chk("write_flags", 32'h10, 32'(s));
    chk("write_be", 32'h3, 32'(s_be));
    chk("write_marks", 32'h4, 32'(acc));
    chk("write_done", 32'h9, 32'(d));
  endtask

  // Load-linked read that hits an armed breakpoint.
  task automatic t_read();
    ibp = 1'b1;
    xfer(mk(ispc_pkg::ISPC_READ, 30'h00000001, 4'h8, 5'h00, 5'h14), 1'b0);
    ibp = 1'b0;
    chk("read_flags", 32'h20, 32'(s));
    chk("read_marks", 32'hA, 32'(acc));
    chk("read_be", 32'h8, 32'(s_be));
  endtask

  // Sync transfers carry their type in address bits 10:6.
  task automatic t_sync();
    logic [4:0] st[2] = '{5'h1F, 5'h0A};
    for (int k = 0; k < 2; k++)
    begin
      xfer(mk(ispc_pkg::ISPC_SYNC, 30'h0, 4'h0, st[k], 5'h00), 1'b0);
      chk("sync_strobes", 32'h1, 32'(s[5:3]));
      chk("sync_type", 32'(st[k]), 32'(s_addr[10:6]));
    end
  endtask

  // Error, requested abort and unrequested acknowledge.
  task automatic t_faults();
    err_c = 1'b1;
    xfer(mk(ispc_pkg::ISPC_READ, 30'h00000040, 4'hF, 5'h00, 5'h00), 1'b0);
    err_c = 1'b0;
    chk("err_done", 32'hC, 32'(d));
    wait_c = 8'h0A;
    xfer(mk(ispc_pkg::ISPC_READ, 30'h00000041, 4'hF, 5'h00, 5'h00), 1'b1);
    wait_c = 8'h04;
    chk("abort_seen", 32'h1, 32'(acc[0]));
    chk("abort_done", 32'hA, 32'(d));
    ack_c = 1'b1;
    xfer(mk(ispc_pkg::ISPC_READ, 30'h00000042, 4'hF, 5'h00, 5'h00), 1'b0);
    ack_c = 1'b0;
    chk("stray_done", 32'hC, 32'(d));
  endtask

  // One exception return gives exactly one unlock-all pulse.
  task automatic t_exception_return();
    int n = 0;
    exception_return = 1'b1;
    repeat (6)
    begin
      @(negedge clk_i);
      n += int'(ual === 1'b1);
    end
    exception_return = 1'b0;
    chk("unlock_all", 32'h1, 32'(n));
  endtask

  // Every mix of armed breakpoints and unified mode.
  task automatic t_bpen();
    for (int k = 0; k < 8; k++)
    begin
      {ibp, dbp, uni} = k[2:0];
      repeat (3) @(negedge clk_i);
      chk("bp_enabled", 32'(k[2] | (k[1] & k[0])), 32'(bpe));
    end
    {ibp, dbp, uni} = 3'b000;
  endtask

  // Fills the queue behind a long stall until refused, then drains it.
  task automatic t_fifo();
    int n = 0;
    int m = 0;
    wait_c = 8'h14;
    req_valid_i = 1'b1;
    for (int k = 0; k < 12 && rdy === 1'b1; k++)
    begin
      req_i = mk(ispc_pkg::ISPC_FETCH, 30'(k), 4'hF, 5'h00, 5'h00);
      @(negedge clk_i);
      n++;
    end
    req_valid_i = 1'b0;
    chk("fifo_fill", 32'h1, 32'(n == 8 || n == 9));
    for (int i = 0; i < 800 && m < n; i++)
    begin
      @(negedge clk_i);
      m += int'(done.valid === 1'b1);
    end
    wait_c = 8'h04;
    chk("fifo_drain", 32'(n), 32'(m));
    chk("fifo_empty", 32'h1, 32'(rdy));
  endtask

  // Main sequence.
  initial
  begin
    t_reset();
    t_fetch();
    t_write();
    t_read();
    t_sync();
    t_faults();
    t_exception_return();
    t_bpen();
    t_fifo();
    tally_and_finish();
  end
endmodule // instr_side_sram_port_control_test
